// ---- tws_pin_action.sv ----
// priority selection and application of one pin's four actions
`timescale 1ns/1ns
module tws_pin_action
(
    // current level and enable
    input wire logic level_in,
    input wire logic enable_in,
    // events, highest priority first
    input wire logic ev_soft_in,
    input wire logic ev_ext_in,
    input wire logic ev_cmp_c_in,
    input wire logic ev_cmp_x_in,
    // action fields in the same order
    input wire logic [1:0] act_soft_in,
    input wire logic [1:0] act_ext_in,
    input wire logic [1:0] act_cmp_c_in,
    input wire logic [1:0] act_cmp_x_in,
    // next level
    output logic level_out
);
    import tws_pkg::*;

    function automatic logic apply(input logic lvl, input logic [1:0] act);
        case (act)
            TWS_ACT_SET: apply = 1'b1;
            TWS_ACT_CLEAR: apply = 1'b0;
            TWS_ACT_TOGGLE: apply = ~lvl;
            default: apply = lvl;
        endcase
    endfunction

    // only the highest event that really acts is applied
    always_comb
    begin
        level_out = level_in;
        if (!enable_in)
            level_out = level_in;
        else if (ev_soft_in && act_soft_in != TWS_ACT_NONE)
            level_out = apply(level_in, act_soft_in);
        else if (ev_ext_in && act_ext_in != TWS_ACT_NONE)
            level_out = apply(level_in, act_ext_in);
        else if (ev_cmp_c_in && act_cmp_c_in != TWS_ACT_NONE)
            level_out = apply(level_in, act_cmp_c_in);
        else if (ev_cmp_x_in && act_cmp_x_in != TWS_ACT_NONE)
            level_out = apply(level_in, act_cmp_x_in);
    end
endmodule // tws_pin_action

// ---- tws_pkg.sv ----
// constants, register map and field layout of the waveform output and status channel
package tws_pkg;
    localparam int TWS_ADDR_W = 8;
    localparam int TWS_DATA_W = 32;
    localparam int TWS_CNT_W = 16;

    // register byte offsets
    localparam logic [7:0] TWS_OFF_CONTROL = 8'h60;
    localparam logic [7:0] TWS_OFF_MODE = 8'h64;
    localparam logic [7:0] TWS_OFF_STATUS = 8'h70;
    localparam logic [7:0] TWS_OFF_IRQ_ENABLE = 8'h74;
    localparam logic [7:0] TWS_OFF_IRQ_DISABLE = 8'h78;
    localparam logic [7:0] TWS_OFF_IRQ_MASK = 8'h7c;
    localparam logic [7:0] TWS_OFF_COUNTER = 8'h80;
    localparam logic [7:0] TWS_OFF_COMPARE_A = 8'h84;
    localparam logic [7:0] TWS_OFF_COMPARE_B = 8'h88;
    localparam logic [7:0] TWS_OFF_COMPARE_C = 8'h8c;

    // status bit positions
    localparam int TWS_ST_OVERFLOW = 0;
    localparam int TWS_ST_CMP_A = 2;
    localparam int TWS_ST_CMP_B = 3;
    localparam int TWS_ST_CMP_C = 4;
    localparam int TWS_ST_EXT_TRIG = 7;
    localparam int TWS_ST_CLOCK_ON = 8;
    localparam int TWS_ST_MIRROR_A = 9;
    localparam int TWS_ST_MIRROR_B = 10;
    localparam int TWS_ST_CHANGE_B = 16;
    localparam int TWS_ST_CHANGE_A = 17;
    localparam int TWS_ST_CHANGE_CLK = 18;
    localparam logic [31:0] TWS_IRQ_BITS = 32'h0007_009d;
    localparam logic [31:0] TWS_CHANGE_BITS = 32'h0007_0000;

    // control bit positions
    localparam int TWS_CTL_CLOCK_EN = 1;
    localparam int TWS_CTL_CLOCK_DIS = 2;
    localparam int TWS_CTL_SOFT_TRIG = 3;

    // mode field positions
    localparam int TWS_MD_EDGE = 8;
    localparam int TWS_MD_SOURCE = 10;
    localparam int TWS_MD_EXT_TRIG_EN = 12;
    localparam int TWS_MD_A_CMP_A = 16;
    localparam int TWS_MD_A_CMP_C = 18;
    localparam int TWS_MD_A_EXT = 20;
    localparam int TWS_MD_A_SOFT = 22;
    localparam int TWS_MD_B_CMP_B = 24;
    localparam int TWS_MD_B_CMP_C = 26;
    localparam int TWS_MD_B_EXT = 28;
    localparam int TWS_MD_B_SOFT = 30;
    localparam logic [31:0] TWS_MODE_WRITABLE = 32'hffff_1f00;
    localparam logic [31:0] TWS_MODE_WAVE_BIT = 32'h0000_8000;

    // pin action encodings
    localparam logic [1:0] TWS_ACT_NONE = 2'h0;
    localparam logic [1:0] TWS_ACT_SET = 2'h1;
    localparam logic [1:0] TWS_ACT_CLEAR = 2'h2;
    localparam logic [1:0] TWS_ACT_TOGGLE = 2'h3;

    // event edge and source encodings
    localparam logic [1:0] TWS_EDGE_RISE = 2'h1;
    localparam logic [1:0] TWS_EDGE_FALL = 2'h2;
    localparam logic [1:0] TWS_EDGE_BOTH = 2'h3;
    localparam logic [1:0] TWS_SRC_PIN_B = 2'h0;
    localparam logic [1:0] TWS_SRC_XC0 = 2'h1;
    localparam logic [1:0] TWS_SRC_XC1 = 2'h2;

    localparam logic [15:0] TWS_CNT_MAX = 16'hffff;
    localparam logic [15:0] TWS_CNT_ZERO = 16'h0000;
    localparam logic [31:0] TWS_WORD_ZERO = 32'h0000_0000;
endpackage

// ---- tws_timer.sv ----
// waveform output channel of a 16-bit timer with status, interrupt mask and compare registers
//
// Notes on behaviour
// RL1: one pin A action per cycle: soft trigger, external event, compare C, compare A.
// RL2: action code 00 keeps, 01 sets, 10 clears, 11 inverts the pin.
// RL3: compare C match applies the pin A compare C action.
// RL4: external event from the selected source applies the pin A event action.
// RL5: pin B takes its soft, event, compare C and compare B actions.
// RL6: all pin B actions are ignored while pin B is the trigger input.
// RL7: one pin B action per cycle: soft trigger, external event, compare C, compare B.
// RL8: reading status returns then clears the sticky event and pin change bits.
// RL9: counter wrap from maximum to zero sets overflow bit 0 until read.
// RL10: counter reaching compare A, B or C sets bits 2, 3, 4 until read; compare B sets bit 3 only while pin B is not the event input.
// RL11: valid edge on the trigger source sets bit 7 when trigger enable is high.
// RL12: bits 9, 10 mirror pins A and B; bit 8 shows counter clock on.
// RL13: pin mirror bits need no defined reset value.
// RL14: bits 16 to 18 read 0 after a pin change since last read, else 1.
// RL15: writing ones to interrupt enable sets those enables; zeros do nothing.
// RL16: interrupt mask register reads back the enabled sources.
// RL17: compare A match sets its flag, may interrupt, and drives pin A.
// RL18: counter register returns the live 16-bit count in its low half.
// RL19: a trigger zeroes the counter at the next counter clock edge only.
// RL20: compare A is a 16-bit read/write value in bits 15:0.
// RL21: pin B as event source makes pin B an input, pin A the only output.
// RL22: soft trigger restarts the counter at the next edge while the clock runs.
// RL23: writing ones to interrupt disable clears those enables; zeros do nothing.
// RL24: interrupt output is high while any enabled status bit is set.
`timescale 1ns/1ns
module tws_timer
#(
    parameter int CNT_W = tws_pkg::TWS_CNT_W
)
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [tws_pkg::TWS_ADDR_W-1:0] reg_addr_in,
    input wire logic [tws_pkg::TWS_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [tws_pkg::TWS_DATA_W-1:0] reg_rdata_out,
    // counter clock edge and external clocks
    input wire logic count_tick_in,
    input wire logic xc0_in,
    input wire logic xc1_in,
    input wire logic xc2_in,
    input wire logic external_clock_pin_in,
    // waveform pins
    input wire logic waveform_pin_a_in,
    output logic waveform_pin_a_out,
    output logic waveform_pin_a_oe_out,
    input wire logic waveform_pin_b_in,
    output logic waveform_pin_b_out,
    output logic waveform_pin_b_oe_out,
    // channel interrupt
    output logic channel_irq_out
);
    import tws_pkg::*;

    typedef struct packed {
        logic [15:0] live_count;
        logic [15:0] compare_a_value;
        logic [15:0] compare_b_value;
        logic [15:0] compare_c_value;
        logic [31:0] mode;
        logic counter_clock_on;
        logic trig_pending;
        logic [31:0] sticky;
        logic [31:0] irq_enable;
        logic pin_a;
        logic pin_b;
        logic prev_src;
        logic prev_a;
        logic prev_b;
        logic prev_clk;
        logic [31:0] rdata;
    } tws_state_t;

    tws_state_t state_q;
    tws_state_t state_d;

    // the register layout holds 16-bit counts only
    if (CNT_W != TWS_CNT_W)
    begin : g_width_check
        $error("counter width must be 16 bits");
    end

    logic wr_ctrl;
    logic rd_status;
    logic soft_trig;
    logic src_level;
    logic src_rise;
    logic src_fall;
    logic ext_event;
    logic ext_trig;
    logic single_mode;
    logic tick;
    logic [15:0] count_next;
    logic count_moved;
    logic ev_overflow;
    logic ev_cmp_a;
    logic ev_cmp_b;
    logic ev_cmp_c;
    logic [31:0] set_bits;
    logic [31:0] status_view;
    logic pin_a_next;
    logic pin_b_next;

    function automatic logic [1:0] field(input logic [31:0] word, input int lsb);
        field = word[lsb +: 2];
    endfunction

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    assign wr_ctrl = reg_write_in && hit(reg_addr_in, TWS_OFF_CONTROL);
    assign rd_status = reg_read_in && hit(reg_addr_in, TWS_OFF_STATUS);
    assign soft_trig = wr_ctrl && reg_wdata_in[TWS_CTL_SOFT_TRIG];
    assign single_mode = (field(state_q.mode, TWS_MD_SOURCE) == TWS_SRC_PIN_B); // RL21

    // external event source and edge detection
    always_comb
    begin
        case (field(state_q.mode, TWS_MD_SOURCE))
            TWS_SRC_PIN_B: src_level = waveform_pin_b_in;
            TWS_SRC_XC0: src_level = xc0_in;
            TWS_SRC_XC1: src_level = xc1_in;
            default: src_level = xc2_in;
        endcase
    end

    assign src_rise = src_level && !state_q.prev_src;
    assign src_fall = !src_level && state_q.prev_src;

    always_comb
    begin
        case (field(state_q.mode, TWS_MD_EDGE))
            TWS_EDGE_RISE: ext_event = src_rise;
            TWS_EDGE_FALL: ext_event = src_fall;
            TWS_EDGE_BOTH: ext_event = src_rise || src_fall;
            default: ext_event = 1'b0;
        endcase
    end

    assign ext_trig = ext_event && state_q.mode[TWS_MD_EXT_TRIG_EN]; // RL11

    // counter advance; a pending trigger waits for the counter clock edge
    assign tick = count_tick_in && state_q.counter_clock_on; // RL22
    assign count_next = state_q.trig_pending ? TWS_CNT_ZERO : state_q.live_count + 16'h0001; // RL19
    assign count_moved = tick;
    assign ev_overflow = tick && !state_q.trig_pending && (state_q.live_count == TWS_CNT_MAX); // RL9
    assign ev_cmp_a = count_moved && (count_next == state_q.compare_a_value); // RL10 RL17
    assign ev_cmp_b = count_moved && !single_mode && (count_next == state_q.compare_b_value); // RL10
    assign ev_cmp_c = count_moved && (count_next == state_q.compare_c_value); // RL10

    always_comb
    begin
        set_bits = TWS_WORD_ZERO;
        set_bits[TWS_ST_OVERFLOW] = ev_overflow;
        set_bits[TWS_ST_CMP_A] = ev_cmp_a;
        set_bits[TWS_ST_CMP_B] = ev_cmp_b;
        set_bits[TWS_ST_CMP_C] = ev_cmp_c;
        set_bits[TWS_ST_EXT_TRIG] = ext_trig;
        set_bits[TWS_ST_CHANGE_A] = waveform_pin_a_in != state_q.prev_a;
        set_bits[TWS_ST_CHANGE_B] = waveform_pin_b_in != state_q.prev_b;
        set_bits[TWS_ST_CHANGE_CLK] = external_clock_pin_in != state_q.prev_clk;
    end

    // change bits are kept as "changed" and read inverted
    always_comb
    begin
        status_view = (state_q.sticky & ~TWS_CHANGE_BITS) | (~state_q.sticky & TWS_CHANGE_BITS); // RL14
        status_view[TWS_ST_CLOCK_ON] = state_q.counter_clock_on; // RL12
        status_view[TWS_ST_MIRROR_A] = state_q.pin_a; // RL12 RL13
        status_view[TWS_ST_MIRROR_B] = single_mode ? waveform_pin_b_in : state_q.pin_b; // RL12
    end

    tws_pin_action u_pin_a
    (
        .level_in(state_q.pin_a),
        .enable_in(1'b1),
        .ev_soft_in(soft_trig),
        .ev_ext_in(ext_event),
        .ev_cmp_c_in(ev_cmp_c),
        .ev_cmp_x_in(ev_cmp_a),
        .act_soft_in(field(state_q.mode, TWS_MD_A_SOFT)),
        .act_ext_in(field(state_q.mode, TWS_MD_A_EXT)),
        .act_cmp_c_in(field(state_q.mode, TWS_MD_A_CMP_C)),
        .act_cmp_x_in(field(state_q.mode, TWS_MD_A_CMP_A)),
        .level_out(pin_a_next)
    ); // RL1 RL2 RL3 RL4 RL17

    tws_pin_action u_pin_b
    (
        .level_in(state_q.pin_b),
        .enable_in(!single_mode),
        .ev_soft_in(soft_trig),
        .ev_ext_in(ext_event),
        .ev_cmp_c_in(ev_cmp_c),
        .ev_cmp_x_in(ev_cmp_b),
        .act_soft_in(field(state_q.mode, TWS_MD_B_SOFT)),
        .act_ext_in(field(state_q.mode, TWS_MD_B_EXT)),
        .act_cmp_c_in(field(state_q.mode, TWS_MD_B_CMP_C)),
        .act_cmp_x_in(field(state_q.mode, TWS_MD_B_CMP_B)),
        .level_out(pin_b_next)
    ); // RL5 RL6 RL7

    always_comb
    begin
        state_d = state_q;
        state_d.pin_a = pin_a_next;
        state_d.pin_b = pin_b_next;
        state_d.prev_src = src_level;
        state_d.prev_a = waveform_pin_a_in;
        state_d.prev_b = waveform_pin_b_in;
        state_d.prev_clk = external_clock_pin_in;
        if (tick)
            state_d.live_count = count_next; // RL19
        // a new trigger in the edge's own cycle stays pending
        state_d.trig_pending = (state_q.trig_pending && !tick) || soft_trig || ext_trig; // RL22
        if (wr_ctrl)
        begin
            if (reg_wdata_in[TWS_CTL_CLOCK_DIS])
                state_d.counter_clock_on = 1'b0;
            else if (reg_wdata_in[TWS_CTL_CLOCK_EN])
                state_d.counter_clock_on = 1'b1;
        end
        if (reg_write_in)
        begin
            case (reg_addr_in)
                TWS_OFF_MODE: state_d.mode = reg_wdata_in & TWS_MODE_WRITABLE;
                TWS_OFF_IRQ_ENABLE: state_d.irq_enable = state_q.irq_enable | (reg_wdata_in & TWS_IRQ_BITS); // RL15
                TWS_OFF_IRQ_DISABLE: state_d.irq_enable = state_q.irq_enable & ~reg_wdata_in; // RL23
                TWS_OFF_COMPARE_A: state_d.compare_a_value = reg_wdata_in[15:0]; // RL20
                TWS_OFF_COMPARE_B: state_d.compare_b_value = reg_wdata_in[15:0];
                TWS_OFF_COMPARE_C: state_d.compare_c_value = reg_wdata_in[15:0];
                default: state_d.irq_enable = state_q.irq_enable;
            endcase
        end
        // the set wins over the read clear
        state_d.sticky = (state_q.sticky & ~(rd_status ? TWS_IRQ_BITS : TWS_WORD_ZERO)) | set_bits; // RL8
        state_d.rdata = TWS_WORD_ZERO;
        if (reg_read_in)
        begin
            case (reg_addr_in)
                TWS_OFF_MODE: state_d.rdata = state_q.mode | TWS_MODE_WAVE_BIT;
                TWS_OFF_STATUS: state_d.rdata = status_view; // RL8
                TWS_OFF_IRQ_MASK: state_d.rdata = state_q.irq_enable; // RL16
                TWS_OFF_COUNTER: state_d.rdata = {16'h0000, state_q.live_count}; // RL18
                TWS_OFF_COMPARE_A: state_d.rdata = {16'h0000, state_q.compare_a_value}; // RL20
                TWS_OFF_COMPARE_B: state_d.rdata = {16'h0000, state_q.compare_b_value};
                TWS_OFF_COMPARE_C: state_d.rdata = {16'h0000, state_q.compare_c_value};
                default: state_d.rdata = TWS_WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    assign reg_rdata_out = state_q.rdata;
    assign waveform_pin_a_out = state_q.pin_a;
    assign waveform_pin_a_oe_out = 1'b1;
    assign waveform_pin_b_out = state_q.pin_b;
    assign waveform_pin_b_oe_out = !single_mode; // RL21
    assign channel_irq_out = |(status_view & state_q.irq_enable); // RL24

    a_overflow_set: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL9
        (tick && !state_q.trig_pending && state_q.live_count == TWS_CNT_MAX)
        |=> (state_q.sticky[TWS_ST_OVERFLOW] && state_q.live_count == TWS_CNT_ZERO))
        else $error("overflow flag not set on wrap");
    a_read_clears: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL8
        (rd_status && !ev_cmp_a) ##1 !ev_cmp_a |=> !state_q.sticky[TWS_ST_CMP_A] || $past(ev_cmp_a, 1) == 1'b0
        && !state_q.sticky[TWS_ST_CMP_A])
        else $error("compare a flag survived a status read");
    a_soft_wins_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL1
        (soft_trig && field(state_q.mode, TWS_MD_A_SOFT) == TWS_ACT_CLEAR) |=> !state_q.pin_a)
        else $error("soft trigger lost its priority on pin a");
    a_cmp_a_pin: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL17
        (ev_cmp_a && !soft_trig && !ext_event && !ev_cmp_c
        && field(state_q.mode, TWS_MD_A_CMP_A) == TWS_ACT_TOGGLE)
        |=> (state_q.pin_a != $past(state_q.pin_a)) && state_q.sticky[TWS_ST_CMP_A])
        else $error("compare a did not toggle pin a");
    a_pin_b_held: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL6
        single_mode && !reg_write_in |=> $stable(state_q.pin_b))
        else $error("pin b moved while an input");
    a_trigger_zero: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL19
        (state_q.trig_pending && !tick) |=> (state_q.trig_pending && $stable(state_q.live_count)))
        else $error("trigger acted before a counter edge");
    a_enable_set: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL15
        (reg_write_in && hit(reg_addr_in, TWS_OFF_IRQ_ENABLE) && reg_wdata_in[TWS_ST_CMP_A])
        |=> state_q.irq_enable[TWS_ST_CMP_A])
        else $error("interrupt enable write ignored");
    a_disable_clr: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL23
        (reg_write_in && hit(reg_addr_in, TWS_OFF_IRQ_DISABLE) && reg_wdata_in[TWS_ST_OVERFLOW])
        |=> !state_q.irq_enable[TWS_ST_OVERFLOW])
        else $error("interrupt disable write ignored");
    a_change_read: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL14
        (waveform_pin_a_in != state_q.prev_a) ##1 (reg_read_in && hit(reg_addr_in, TWS_OFF_STATUS))
        |=> !reg_rdata_out[TWS_ST_CHANGE_A])
        else $error("pin a change not reported");
    a_counter_read: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL18
        (reg_read_in && hit(reg_addr_in, TWS_OFF_COUNTER))
        |=> reg_rdata_out == {16'h0000, $past(state_q.live_count)})
        else $error("counter read mismatch");
    a_pin_b_soft: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL7
        (!single_mode && soft_trig && field(state_q.mode, TWS_MD_B_SOFT) == TWS_ACT_SET) |=> state_q.pin_b)
        else $error("soft trigger lost its priority on pin b");
    a_pin_a_event: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL4
        (ext_event && !soft_trig && field(state_q.mode, TWS_MD_A_EXT) == TWS_ACT_TOGGLE)
        |=> state_q.pin_a != $past(state_q.pin_a))
        else $error("external event did not toggle pin a");
    a_event_flag: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL11
        (ext_event && state_q.mode[TWS_MD_EXT_TRIG_EN]) |=> state_q.sticky[TWS_ST_EXT_TRIG])
        else $error("external trigger flag not set");
    a_clock_status: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL12
        (reg_read_in && hit(reg_addr_in, TWS_OFF_STATUS))
        |=> reg_rdata_out[TWS_ST_CLOCK_ON] == $past(state_q.counter_clock_on))
        else $error("clock status bit wrong");
    a_mask_read: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL16
        (reg_read_in && hit(reg_addr_in, TWS_OFF_IRQ_MASK)) |=> reg_rdata_out == $past(state_q.irq_enable))
        else $error("interrupt mask read mismatch");
    a_irq_level: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL24
        (state_q.irq_enable[TWS_ST_OVERFLOW] && state_q.sticky[TWS_ST_OVERFLOW]) |-> channel_irq_out)
        else $error("interrupt missing for a set overflow flag");
    a_zero_match: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL10 RL19
        (tick && state_q.trig_pending && state_q.compare_c_value == TWS_CNT_ZERO)
        |=> (state_q.live_count == TWS_CNT_ZERO && state_q.sticky[TWS_ST_CMP_C]))
        else $error("restart did not match compare c at zero");
endmodule // tws_timer

// ---- tws_timer_test.sv ----
// self-checking testbench of the waveform output and status channel
`timescale 1ns/1ns
module tws_timer_test;
    import tws_pkg::*;
    localparam logic [1:0] K0 = TWS_ACT_NONE;
    localparam logic [1:0] K1 = TWS_ACT_SET;
    localparam logic [1:0] K2 = TWS_ACT_CLEAR;
    localparam logic [1:0] K3 = TWS_ACT_TOGGLE;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, tick = 1'b0, tw = 1'b0;
    logic clk_pin = 1'b0, pb_drv = 1'b0, rd_seen = 1'b0, pa = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, v, e;
    logic [2:0] xc = 3'h0;
    logic pa_out, pa_oe, pb_out, pb_oe, irq, pa_w, pb_w;
    logic [31:0] exp_q[$], msk_q[$];
    int bad_count = 0, tests_run = 0, cyc = 0, s, c, l;

    // wire levels seen by the pin inputs
    assign pa_w = pa_oe ? pa_out : 1'b0;
    assign pb_w = pb_oe ? pb_out : pb_drv;

    tws_timer dut (
        .core_clk_in(clk), .resetn_in(resetn),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_en), .reg_read_in(rd_en),
        .reg_rdata_out(rdata), .count_tick_in(tick),
        .xc0_in(xc[0]), .xc1_in(xc[1]), .xc2_in(xc[2]), .external_clock_pin_in(clk_pin),
        .waveform_pin_a_in(pa_w), .waveform_pin_a_out(pa_out), .waveform_pin_a_oe_out(pa_oe),
        .waveform_pin_b_in(pb_w), .waveform_pin_b_out(pb_out), .waveform_pin_b_oe_out(pb_oe),
        .channel_irq_out(irq)
    );

    always #50 clk = ~clk;

    function automatic logic [31:0] md(input logic [1:0] bs, be, bc, bb, as, ae, ac, aa, input logic [4:0] ctl);
        return {bs, be, bc, bb, as, ae, ac, aa, 3'h0, ctl, 8'h00};
    endfunction

    task automatic chk(input logic [31:0] ex, input logic [31:0] got);
        tests_run++;
        if (got !== ex)
        begin
            $display("mismatch at %0t: expected %h got %h", $time, ex, got);
            bad_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        tick <= tw;
        @(posedge clk);
        wr_en <= 1'b0;
        tick <= 1'b0;
    endtask

    // the expected word is noted before the strobe goes out
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
        exp_q.push_back(ex);
        msk_q.push_back(m);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    task automatic ticks(input int n);
        @(posedge clk);
        tick <= 1'b1;
        repeat (n) @(posedge clk);
        tick <= 1'b0;
    endtask

    task automatic test_done;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (rd_seen)
        begin
            chk(exp_q[0] & msk_q[0], rdata & msk_q[0]);
            exp_q.delete(0);
            msk_q.delete(0);
        end
        rd_seen <= rd_en;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            bad_count++;
            test_done();
        end
    end

    initial
    begin
        v = $urandom(32'h8200a0fb);
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd(TWS_OFF_STATUS, 32'h0007_0000, 32'hffff_f9ff);
        rd(TWS_OFF_IRQ_MASK, 32'h0, ALL);
        rd(TWS_OFF_COUNTER, 32'h0, ALL);
        rd(8'h90, 32'h0, ALL);
        v = $urandom;
        wr(TWS_OFF_COMPARE_A, v);
        rd(TWS_OFF_COMPARE_A, {16'h0000, v[15:0]}, ALL);
        wr(TWS_OFF_IRQ_MASK, ALL);
        wr(TWS_OFF_COUNTER, ALL);
        wr(8'h90, ALL);
        rd(TWS_OFF_IRQ_MASK, 32'h0, ALL);
        rd(TWS_OFF_COUNTER, 32'h0, ALL);
        // interrupt enable, disable and mask
        wr(TWS_OFF_IRQ_ENABLE, ALL);
        rd(TWS_OFF_IRQ_MASK, TWS_IRQ_BITS, ALL);
        @(negedge clk);
        chk(32'(irq), 32'h1);
        wr(TWS_OFF_IRQ_DISABLE, 32'h0000_0005);
        wr(TWS_OFF_IRQ_ENABLE, 32'h0);
        wr(TWS_OFF_IRQ_DISABLE, 32'h0);
        rd(TWS_OFF_IRQ_MASK, TWS_IRQ_BITS & 32'hffff_fffa, ALL);
        wr(TWS_OFF_IRQ_DISABLE, ALL);
        wr(TWS_OFF_IRQ_ENABLE, 32'h0000_0001);
        rd(TWS_OFF_IRQ_MASK, 32'h0000_0001, ALL);
        // counting, compares A and B, soft trigger restart
        wr(TWS_OFF_MODE, md(K0, K0, K0, K1, K0, K0, K0, K3, {1'b0, TWS_SRC_XC0, 2'h0}));
        wr(TWS_OFF_COMPARE_A, 32'h0000_0005);
        wr(TWS_OFF_COMPARE_B, 32'h0000_0003);
        wr(TWS_OFF_CONTROL, 32'h0000_0002);
        ticks(7);
        rd(TWS_OFF_COUNTER, 32'h0000_0007, ALL);
        rd(TWS_OFF_STATUS, 32'h0004_070c, ALL);
        rd(TWS_OFF_STATUS, 32'h0007_0700, ALL);
        wr(TWS_OFF_CONTROL, 32'h0000_0008);
        rd(TWS_OFF_COUNTER, 32'h0000_0007, ALL);
        ticks(1);
        rd(TWS_OFF_COUNTER, 32'h0, ALL);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        ticks(65536);
        @(negedge clk);
        chk(32'(irq), 32'h1);
        rd(TWS_OFF_STATUS, 32'h0000_011d, 32'h0000_019d);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        // every action code from both levels on both pins
        for (l = 0; l < 2; l++)
            for (c = 0; c < 4; c++)
            begin
                wr(TWS_OFF_MODE, md(l ? K1 : K2, K0, K0, K0, l ? K1 : K2, K0, K0, K0, 5'h04));
                wr(TWS_OFF_CONTROL, 32'h0000_0008);
                wr(TWS_OFF_MODE, md(2'(c), K0, K0, K0, 2'(c), K0, K0, K0, 5'h04));
                wr(TWS_OFF_CONTROL, 32'h0000_0008);
                e = (c == 0) ? l : (c == 1) ? 1 : (c == 2) ? 0 : !l;
                @(negedge clk);
                chk(32'(pa_out), e);
                chk(32'(pb_out), e);
            end
        wr(TWS_OFF_MODE, md(K3, K0, K0, K0, K0, K0, K0, K0, 5'h00));
        wr(TWS_OFF_CONTROL, 32'h0000_0008);
        @(negedge clk);
        chk({30'h0, pa_oe, pb_oe}, 32'h2);
        chk(32'(pb_out), 32'h0);
        // simultaneous actions on both pins
        wr(TWS_OFF_MODE, md(K1, K0, K0, K0, K1, K0, K0, K0, 5'h04));
        wr(TWS_OFF_CONTROL, 32'h0000_0008);
        wr(TWS_OFF_COMPARE_A, 32'h0);
        wr(TWS_OFF_COMPARE_B, 32'h0);
        wr(TWS_OFF_COMPARE_C, 32'h0);
        wr(TWS_OFF_MODE, md(K2, K0, K1, K3, K2, K0, K1, K3, 5'h04));
        tw = 1'b1;
        wr(TWS_OFF_CONTROL, 32'h0000_0008);
        tw = 1'b0;
        @(negedge clk);
        chk({30'h0, pa_out, pb_out}, 32'h0);
        wr(TWS_OFF_MODE, md(K0, K0, K1, K2, K0, K0, K1, K2, 5'h04));
        ticks(1);
        @(negedge clk);
        chk({30'h0, pa_out, pb_out}, 32'h3);
        // external events from every source
        pa = 1'b1;
        for (s = 0; s < 4; s++)
        begin
            wr(TWS_OFF_MODE, md(K0, K0, K0, K0, K0, K3, K0, K0, {1'b1, 2'(s), TWS_EDGE_RISE}));
            rd(TWS_OFF_STATUS, 32'h0, 32'h0000_0080);
            xc <= (s == 0) ? 3'h7 : 3'(~(3'h1 << (s - 1)));
            repeat (3) @(posedge clk);
            if (s == 0)
                pb_drv <= 1'b1;
            else
                xc <= 3'h7;
            repeat (3) @(posedge clk);
            pa = !pa;
            @(negedge clk);
            chk(32'(pa_out), 32'(pa));
            rd(TWS_OFF_STATUS, {22'h0, pa, 9'h080}, 32'h0000_0280);
            xc <= 3'h0;
            pb_drv <= 1'b0;
            repeat (3) @(posedge clk);
        end
        wr(TWS_OFF_MODE, md(K0, K0, K0, K0, K0, K3, K0, K0, {1'b0, TWS_SRC_XC0, TWS_EDGE_BOTH}));
        rd(TWS_OFF_STATUS, 32'h0, 32'h0000_0080);
        xc <= 3'h1;
        clk_pin <= 1'b1;
        repeat (3) @(posedge clk);
        pa = !pa;
        rd(TWS_OFF_STATUS, {22'h0, pa, 9'h000}, 32'h0004_0280);
        rd(TWS_OFF_STATUS, 32'h0004_0000, 32'h0004_0000);
        wr(TWS_OFF_MODE, md(K0, K0, K0, K0, K0, K3, K0, K0, {1'b0, TWS_SRC_XC0, TWS_EDGE_FALL}));
        xc <= 3'h0;
        repeat (3) @(posedge clk);
        pa = !pa;
        @(negedge clk);
        chk(32'(pa_out), 32'(pa));
        // clock off wins over clock on in one control write
        wr(TWS_OFF_CONTROL, 32'h0000_0006);
        rd(TWS_OFF_STATUS, 32'h0, 32'h0000_0100);
        repeat (3) @(posedge clk);
        test_done();
    end
endmodule // tws_timer_test
